// ===== include/srs_pkg.sv
package srs_pkg;

  // ==========================================================
  // Widths and counts
  localparam int SRS_DATA_W = 8;
  localparam int SRS_ADDR_W = 8;
  localparam int SRS_WORD_W = 16;
  localparam int SRS_NUM_RESULT = 3;
  localparam int SRS_KEY_BYTES = 4;

  // ==========================================================
  // Byte offsets on the host register port
  localparam logic [7:0] SRS_OFS_PROX_CH2_LO = 8'h28;
  localparam logic [7:0] SRS_OFS_PROX_CH2_HI = 8'h29;
  localparam logic [7:0] SRS_OFS_PROX_CH3_LO = 8'h2A;
  localparam logic [7:0] SRS_OFS_PROX_CH3_HI = 8'h2B;
  localparam logic [7:0] SRS_OFS_AUX_UV_LO = 8'h2C;
  localparam logic [7:0] SRS_OFS_AUX_UV_HI = 8'h2D;
  localparam logic [7:0] SRS_OFS_PARAM_MAILBOX = 8'h2E;
  localparam logic [7:0] SRS_OFS_POWER_STATUS = 8'h30;
  localparam logic [7:0] SRS_OFS_KEY_FIRST = 8'h3B;

  // ==========================================================
  // Result channel indices on the sequencer side
  localparam logic [1:0] SRS_CH_PROX2 = 2'h0;
  localparam logic [1:0] SRS_CH_PROX3 = 2'h1;
  localparam logic [1:0] SRS_CH_AUX_UV = 2'h2;

  // ==========================================================
  // Values after reset
  localparam logic [15:0] SRS_RESULT_RESET = 16'h0000;
  localparam logic [7:0] SRS_MAILBOX_RESET = 8'h00;
  localparam logic [7:0] SRS_STATUS_RESET = 8'h00;
  localparam logic [31:0] SRS_KEY_RESET = 32'h0000_0000;
  localparam logic [7:0] SRS_UNMAPPED_READ = 8'h00;

  // ==========================================================
  // Power status field positions
  localparam int SRS_STAT_SLEEP_BIT = 0;
  localparam int SRS_STAT_SUSPEND_BIT = 1;
  localparam int SRS_STAT_AWAKE_BIT = 2;

  typedef enum logic [1:0] {
    SRS_PWR_NONE,
    SRS_PWR_SLEEP,
    SRS_PWR_SUSPEND,
    SRS_PWR_AWAKE
  } srs_pwr_e;

endpackage

// ===== rtl/srs_result_word.sv
`timescale 1ns/1ps
module srs_result_word #(
  parameter int WORD_W = srs_pkg::SRS_WORD_W
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic meas_wr_i,
  input wire logic [WORD_W-1:0] meas_data_i,
  input wire logic host_wr_lo_i,
  input wire logic host_wr_hi_i,
  input wire logic [WORD_W/2-1:0] host_wdata_i,
  output logic [WORD_W-1:0] word_o
);

  localparam int HALF_W = WORD_W / 2;

  // Elaboration check: the word is always split into two host bytes
  if (WORD_W != 2 * srs_pkg::SRS_DATA_W) begin : g_bad_word_w
    $error("srs_result_word: WORD_W must be two bytes");
  end

  // ==========================================================
  // Storage: a fresh measurement beats a host write in the same cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      word_o <= srs_pkg::SRS_RESULT_RESET;
    end else if (ce_i) begin
      if (meas_wr_i) begin
        word_o <= meas_data_i;
      end else begin
        if (host_wr_lo_i) begin
          word_o[HALF_W-1:0] <= host_wdata_i;
        end
        if (host_wr_hi_i) begin
          word_o[WORD_W-1:HALF_W] <= host_wdata_i;
        end
      end
    end
  end

endmodule

// ===== rtl/srs_regs.sv
`timescale 1ns/1ps
module srs_regs #(
  parameter int DATA_W = srs_pkg::SRS_DATA_W,
  parameter int ADDR_W = srs_pkg::SRS_ADDR_W
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic meas_wr_i,
  input wire logic [1:0] meas_chan_i,
  input wire logic [2*DATA_W-1:0] meas_data_i,
  input wire logic mbox_wr_i,
  input wire logic [DATA_W-1:0] mbox_data_i,
  input wire logic awake_flag_i,
  input wire logic suspend_i,
  input wire logic sleep_i,
  input wire logic [DATA_W-1:0] irq_status_i,
  input wire logic [DATA_W-1:0] irq_enable_i,
  output logic int_o,
  output logic [2*DATA_W-1:0] prox_ch2_result_o,
  output logic [2*DATA_W-1:0] prox_ch3_result_o,
  output logic [2*DATA_W-1:0] uv_level_result_o,
  output logic [DATA_W-1:0] param_mailbox_out_o,
  output logic [8*srs_pkg::SRS_KEY_BYTES-1:0] reserved_key_area_o
);

  localparam int NRES = srs_pkg::SRS_NUM_RESULT;
  localparam int NKEY = srs_pkg::SRS_KEY_BYTES;

  localparam logic [7:0] RES_LO_OFS [NRES] = '{
    srs_pkg::SRS_OFS_PROX_CH2_LO,
    srs_pkg::SRS_OFS_PROX_CH3_LO,
    srs_pkg::SRS_OFS_AUX_UV_LO
  };
  localparam logic [7:0] RES_HI_OFS [NRES] = '{
    srs_pkg::SRS_OFS_PROX_CH2_HI,
    srs_pkg::SRS_OFS_PROX_CH3_HI,
    srs_pkg::SRS_OFS_AUX_UV_HI
  };
  localparam logic [1:0] RES_CHAN [NRES] = '{
    srs_pkg::SRS_CH_PROX2,
    srs_pkg::SRS_CH_PROX3,
    srs_pkg::SRS_CH_AUX_UV
  };

  // ==========================================================
  // Elaboration checks: refuse sizes the decode cannot serve
  if (DATA_W != 8) begin : g_bad_data_w
    $error("srs_regs: registers are one byte wide");
  end
  if (ADDR_W != 8) begin : g_bad_addr_w
    $error("srs_regs: offsets need an 8-bit address");
  end
  if (NRES != 3) begin : g_bad_nres
    $error("srs_regs: three result words are mapped");
  end
  if (NKEY != 4) begin : g_bad_nkey
    $error("srs_regs: the key area spans four bytes");
  end
  if (srs_pkg::SRS_STAT_AWAKE_BIT >= DATA_W) begin : g_bad_stat_bit
    $error("srs_regs: status flags must fit in one byte");
  end
  // Key bytes sit above the status byte, so the read decode never overlaps
  if (srs_pkg::SRS_OFS_KEY_FIRST <= srs_pkg::SRS_OFS_POWER_STATUS) begin : g_bad_key_ofs
    $error("srs_regs: key area overlaps the status byte");
  end

  // ==========================================================
  // Result words
  logic [2*DATA_W-1:0] res_word [NRES];

  genvar gi;
  generate
    for (gi = 0; gi < NRES; gi++) begin : g_res
      logic hit_lo;
      logic hit_hi;
      logic meas_hit;
      assign hit_lo = reg_wr_i && (reg_addr_i == RES_LO_OFS[gi]);
      assign hit_hi = reg_wr_i && (reg_addr_i == RES_HI_OFS[gi]);
      // No unread check: a new result overwrites, the host must keep pace
      assign meas_hit = meas_wr_i && (meas_chan_i == RES_CHAN[gi]);
      srs_result_word #(
        .WORD_W(2 * DATA_W)
      ) u_word (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .meas_wr_i(meas_hit),
        .meas_data_i(meas_data_i),
        .host_wr_lo_i(hit_lo),
        .host_wr_hi_i(hit_hi),
        .host_wdata_i(reg_wdata_i),
        .word_o(res_word[gi])
      );
    end
  endgenerate

  assign prox_ch2_result_o = res_word[0];
  assign prox_ch3_result_o = res_word[1];
  assign uv_level_result_o = res_word[2];

  // ==========================================================
  // Parameter mailbox
  logic mbox_host_wr;
  assign mbox_host_wr = reg_wr_i && (reg_addr_i == srs_pkg::SRS_OFS_PARAM_MAILBOX);

  // Sequencer answers to parameter queries win over host writes
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      param_mailbox_out_o <= srs_pkg::SRS_MAILBOX_RESET;
    end else if (ce_i) begin
      if (mbox_wr_i) begin
        param_mailbox_out_o <= mbox_data_i;
      end else if (mbox_host_wr) begin
        param_mailbox_out_o <= reg_wdata_i;
      end
    end
  end

  // ==========================================================
  // Power state tracking
  srs_pkg::srs_pwr_e pwr_reg;
  srs_pkg::srs_pwr_e pwr_next;

  // Flags should be exclusive; if not, the more awake state is shown
  always_comb begin
    if (awake_flag_i) begin
      pwr_next = srs_pkg::SRS_PWR_AWAKE;
    end else if (suspend_i) begin
      pwr_next = srs_pkg::SRS_PWR_SUSPEND;
    end else if (sleep_i) begin
      pwr_next = srs_pkg::SRS_PWR_SLEEP;
    end else begin
      pwr_next = srs_pkg::SRS_PWR_NONE;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwr_reg <= srs_pkg::SRS_PWR_NONE;
    end else if (ce_i) begin
      pwr_reg <= pwr_next;
    end
  end

  logic [DATA_W-1:0] status_byte;

  always_comb begin
    status_byte = srs_pkg::SRS_STATUS_RESET;
    case (pwr_reg)
      srs_pkg::SRS_PWR_AWAKE: begin
        status_byte[srs_pkg::SRS_STAT_AWAKE_BIT] = 1'b1;
      end
      srs_pkg::SRS_PWR_SUSPEND: begin
        status_byte[srs_pkg::SRS_STAT_SUSPEND_BIT] = 1'b1;
      end
      srs_pkg::SRS_PWR_SLEEP: begin
        status_byte[srs_pkg::SRS_STAT_SLEEP_BIT] = 1'b1;
      end
      default: begin
        status_byte = srs_pkg::SRS_STATUS_RESET;
      end
    endcase
  end

  // ==========================================================
  // Reserved key area, first offset holds the top byte
  logic [7:0] key_byte [NKEY];

  genvar gk;
  generate
    for (gk = 0; gk < NKEY; gk++) begin : g_key
      localparam logic [7:0] KOFS = srs_pkg::SRS_OFS_KEY_FIRST + 8'(gk);
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          key_byte[gk] <= srs_pkg::SRS_KEY_RESET[8*(NKEY-1-gk) +: 8];
        end else if (ce_i && reg_wr_i && (reg_addr_i == KOFS)) begin
          key_byte[gk] <= reg_wdata_i;
        end
      end
      assign reserved_key_area_o[8*(NKEY-1-gk) +: 8] = key_byte[gk];
    end
  endgenerate

  // ==========================================================
  // Read path: data is taken before any same-cycle update lands
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = srs_pkg::SRS_UNMAPPED_READ;
    for (int i = 0; i < NRES; i++) begin
      if (reg_addr_i == RES_LO_OFS[i]) begin
        rd_mux = res_word[i][DATA_W-1:0];
      end
      if (reg_addr_i == RES_HI_OFS[i]) begin
        rd_mux = res_word[i][2*DATA_W-1:DATA_W];
      end
    end
    for (int k = 0; k < NKEY; k++) begin
      if (reg_addr_i == srs_pkg::SRS_OFS_KEY_FIRST + 8'(k)) begin
        rd_mux = key_byte[k];
      end
    end
    if (reg_addr_i == srs_pkg::SRS_OFS_PARAM_MAILBOX) begin
      rd_mux = param_mailbox_out_o;
    end
    if (reg_addr_i == srs_pkg::SRS_OFS_POWER_STATUS) begin
      rd_mux = status_byte;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= srs_pkg::SRS_UNMAPPED_READ;
    end else if (ce_i && reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // ==========================================================
  // Interrupt request
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      int_o <= 1'b0;
    end else if (ce_i) begin
      int_o <= |(irq_status_i & irq_enable_i);
    end
  end

endmodule

// ===== tb/srs_regs_assertions.sv
`timescale 1ns/1ps
module srs_regs_checker (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic meas_wr_i,
  input wire logic [1:0] meas_chan_i,
  input wire logic [15:0] meas_data_i,
  input wire logic mbox_wr_i,
  input wire logic [7:0] mbox_data_i,
  input wire logic awake_flag_i,
  input wire logic suspend_i,
  input wire logic sleep_i,
  input wire logic [7:0] irq_status_i,
  input wire logic [7:0] irq_enable_i,
  input wire logic int_o,
  input wire logic [15:0] prox_ch2_result_o,
  input wire logic [15:0] prox_ch3_result_o,
  input wire logic [15:0] uv_level_result_o,
  input wire logic [7:0] param_mailbox_out_o,
  input wire logic [31:0] reserved_key_area_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic irq_any;
  assign irq_any = |(irq_status_i & irq_enable_i);
  // ==========================================================
  // Answers and loads
  a_read_answered: assert property (ce_i && reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  a_int_follows: assert property (ce_i |=> int_o == $past(irq_any))
    else $error("int mismatch");
  a_ch2_load: assert property (ce_i && meas_wr_i && meas_chan_i == 2'h0
    |=> prox_ch2_result_o == $past(meas_data_i))
    else $error("ch2 load");
  a_ch3_load: assert property (ce_i && meas_wr_i && meas_chan_i == 2'h1
    |=> prox_ch3_result_o == $past(meas_data_i))
    else $error("ch3 load");
  a_uv_load: assert property (ce_i && meas_wr_i && meas_chan_i == 2'h2
    |=> uv_level_result_o == $past(meas_data_i))
    else $error("uv load");
  a_mbox_load: assert property (ce_i && mbox_wr_i |=> param_mailbox_out_o == $past(mbox_data_i))
    else $error("mailbox load");
  // Only one power flag may show; reserved bits stay low
  a_status_shape: assert property (ce_i && reg_rd_i && reg_addr_i == 8'h30 && !reg_wr_i
    |=> reg_rdata_o[7:3] == 5'h00 && $onehot0(reg_rdata_o[2:0]))
    else $error("status shape");
  // A status read shows the flags registered one edge before the read
  a_sleep_shown: assert property (ce_i && $past(ce_i) && $past(arst_n_i) && reg_rd_i
    && !reg_wr_i && reg_addr_i == 8'h30 && $past(sleep_i) && !$past(suspend_i)
    && !$past(awake_flag_i) |=> reg_rdata_o == 8'h01)
    else $error("sleep flag not shown");
  a_awake_shown: assert property (ce_i && $past(ce_i) && $past(arst_n_i) && reg_rd_i
    && reg_addr_i == 8'h30 && $past(awake_flag_i) |=> reg_rdata_o == 8'h04)
    else $error("awake flag not shown");
  a_key_store: assert property (ce_i && reg_wr_i && reg_addr_i == 8'h3B
    |=> reserved_key_area_o[31:24] == $past(reg_wdata_i))
    else $error("key store");
  c_meas: cover property (ce_i && meas_wr_i);
  c_read: cover property (reg_rvalid_o);
  c_int: cover property (int_o);
endmodule

bind srs_regs srs_regs_checker srs_regs_checker_i (.*);

// ===== tb/srs_host_model.sv
`timescale 1ns/1ps
module srs_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  // ==========================================================
  // Idle bus shows inverted last values, never a stale match
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Key area is touched to prove the plain store and, after the mid-run reset, its zero reset value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  // Caller reads results before the next measurement; params via mailbox
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
    v = rvalid_i;
  endtask
endmodule

// ===== tb/srs_regs_tb_top.sv
`timescale 1ns/1ps
module srs_regs_tb_top;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic ce = 1'b1;
  logic meas_wr = 1'b0;
  logic [1:0] chan = 2'h0;
  logic [15:0] mdata = 16'h0000;
  logic mbox_wr = 1'b0;
  logic [7:0] mbox = 8'h00;
  logic [2:0] pwr = 3'h0;
  logic [7:0] irq_s = 8'h00;
  logic [7:0] irq_e = 8'h00;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd, rvalid, int_o, v;
  logic [31:0] key;
  logic [15:0] exp_w [3] = '{default: 16'h0000};
  int failures = 0;
  int n_tests = 0;
  always #5 clk_i = ~clk_i;
  srs_regs srs_regs_i (.clk_i, .arst_n_i, .ce_i(ce), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .meas_wr_i(meas_wr), .meas_chan_i(chan), .meas_data_i(mdata),
    .mbox_wr_i(mbox_wr), .mbox_data_i(mbox), .awake_flag_i(pwr[2]), .suspend_i(pwr[1]),
    .sleep_i(pwr[0]), .irq_status_i(irq_s), .irq_enable_i(irq_e), .int_o,
    .prox_ch2_result_o(), .prox_ch3_result_o(), .uv_level_result_o(),
    .param_mailbox_out_o(), .reserved_key_area_o());
  srs_host_model srs_host_model_i (.clk_i, .rdata_i(rdata), .rvalid_i(rvalid),
    .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    srs_host_model_i.rd(a, d, v);
    chk({v, d}, {1'b1, e});
  endtask
  // Most-awake flag wins when several are high
  function automatic logic [7:0] stat_exp(input logic [2:0] p);
    if (p[2]) return 8'h04;
    if (p[1]) return 8'h02;
    return {7'h00, p[0]};
  endfunction
  task automatic complete_run();
    $display("Tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #50us;
    failures++;
    complete_run();
  end
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'hEA91));
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    arst_n_i = 1'b1;
    for (int a = 8'h28; a <= 8'h31; a++) rdchk(8'(a), 8'h00);
    for (int i = 0; i < 12; i++) begin
      @(negedge clk_i);
      meas_wr = 1'b1;
      chan = (i < 4) ? 2'(i) : 2'($urandom_range(3));
      mdata = 16'($urandom);
      if (chan != 2'h3) exp_w[chan] = mdata;
      @(negedge clk_i);
      meas_wr = 1'b0;
      for (int c = 0; c < 3; c++) begin
        rdchk(8'h28 + 8'(2 * c), exp_w[c][7:0]);
        rdchk(8'h29 + 8'(2 * c), exp_w[c][15:8]);
      end
    end
    // A measurement offered while the clock enable is low must not land
    @(negedge clk_i);
    ce = 1'b0;
    meas_wr = 1'b1;
    chan = 2'h0;
    mdata = ~exp_w[0];
    @(negedge clk_i);
    meas_wr = 1'b0;
    ce = 1'b1;
    rdchk(8'h28, exp_w[0][7:0]);
    srs_host_model_i.wr(8'h2B, 8'hA5);
    rdchk(8'h2B, 8'hA5);
    @(negedge clk_i);
    mbox_wr = 1'b1;
    mbox = 8'($urandom);
    @(negedge clk_i);
    mbox_wr = 1'b0;
    rdchk(8'h2E, mbox);
    srs_host_model_i.wr(8'h2E, ~mbox);
    rdchk(8'h2E, ~mbox);
    for (int p = 1; p < 8; p++) begin
      pwr = 3'(p);
      srs_host_model_i.wr(8'h30, 8'hFF);
      rdchk(8'h30, stat_exp(3'(p)));
    end
    for (int i = 0; i < 16; i++) begin
      irq_s = 8'($urandom);
      irq_e = (i == 0) ? ~irq_s : 8'($urandom);
      @(negedge clk_i);
      chk(int_o, |(irq_s & irq_e));
    end
    key = $urandom;
    for (int k = 0; k < 4; k++) srs_host_model_i.wr(8'h3B + 8'(k), key[31 - 8 * k -: 8]);
    for (int k = 0; k < 4; k++) rdchk(8'h3B + 8'(k), key[31 - 8 * k -: 8]);
    rdchk(8'h3F, 8'h00);
    // Mid-run reset: every byte written above must come back as zero
    pwr = 3'h0;
    @(negedge clk_i);
    arst_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    arst_n_i = 1'b1;
    for (int a = 8'h28; a <= 8'h3E; a++) rdchk(8'(a), 8'h00);
    complete_run();
  end
endmodule
